/* File: core/gds_pkg.sv */
// Package of types and constants for the gate driver supply sequencer
package gds_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 40;
  localparam int REQ_PERIOD_US     = 10;
  localparam int REQ_PERIOD_CYC    = REQ_PERIOD_US * CLK_MHZ;
  localparam int WD_UNIT_US        = 100;
  localparam int WD_UNIT_CYC       = WD_UNIT_US * CLK_MHZ;
  localparam int WD_CFG_W          = 3;
  localparam int CNT_W             = 24;

  localparam logic [11:0] ADC_ZERO = 12'h000;
  localparam int SEL_W             = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lvInputSupplyUv;   // low-side input supply below UV
    logic lvLogicUv;         // low-side logic supply at/below UV
    logic hvInputUv;         // high-side input supply below UV
    logic hvInputOv;         // high-side input supply above OV
    logic hvLogicOk;         // high-side internal logic in regulation
    logic gateSupplyUv;      // gate supply below UV
    logic referenceUv;       // reference below UV
    logic negSupplyOor;      // negative supply out of range
  } gds_cmp_t;

  typedef struct packed {
    logic lvInput;
    logic lvLogic;
    logic hvInput;
    logic reference;
  } gds_por_t;

  typedef struct packed {
    logic hvSupplyOv;
    logic gateSupplyUv;
    logic referenceUv;
    logic negSupplyOor;
    logic watchdog;
  } gds_fault_t;

  typedef struct packed {
    logic hvSupplyOv;
    logic gateSupplyUv;
    logic referenceUv;
  } gds_mask_t;

  typedef enum logic [1:0] {LvOff, LvRequest, LvNormal, LvDown} gds_lv_state_t;
  typedef enum logic [1:0] {HvOff, HvRamp, HvRun, HvDown} gds_hv_state_t;

endpackage

/* File: core/gds_sync.sv */
// Two-stage synchroniser for one comparator flag
`timescale 1ns/1ps
module gds_sync
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic metaQ;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      metaQ <= 1'b0;
      dout  <= 1'b0;
    end
    else
    begin
      metaQ <= din;
      dout  <= metaQ;
    end
  end
endmodule

/* File: core/gds_wdog.sv */
// Watchdog timer for one supply held below power-on reset
`timescale 1ns/1ps
module gds_wdog
  import gds_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                porLow,
  input  wire logic [WD_CFG_W-1:0] timeoutSel,
  output logic                     expired
);
  logic [CNT_W-1:0] cntQ;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(WD_UNIT_CYC) * CNT_W'({1'b0, timeoutSel} + 4'h1);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cntQ <= '0;
    else if (!porLow)
      cntQ <= '0;
    else if (cntQ != limit)
      cntQ <= cntQ + CNT_W'(1);
  end

  assign expired = porLow && (cntQ == limit);
endmodule

/* File: core/gds_sequencer.sv */
// Supply supervision and power sequencing for a two-domain gate driver
`timescale 1ns/1ps
module gds_sequencer
  import gds_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire gds_pkg::gds_cmp_t    cmpIn,
  input  wire gds_pkg::gds_por_t    porIn,
  input  wire logic                 hvReplyValid,
  input  wire logic                 pwmIn,
  input  wire logic                 hvFailsafeEnable,
  input  wire logic                 hvFailsafeInput,
  input  wire logic                 failsafeGateStateInput,
  input  wire logic                 failsafeMode,
  input  wire logic                 linkFault,
  input  wire logic                 spiFault,
  input  wire logic                 overcurrentFault,
  input  wire logic                 desaturationFault,
  input  wire logic                 overtempWarning,
  input  wire gds_pkg::gds_mask_t   faultMaskTwo,
  input  wire logic                 negSupplyMonitorEnable,
  input  wire logic                 gateSelectA,
  input  wire logic [2:0]           gateUvThresholdSel,
  input  wire logic [2:0]           gateSupplyVoltageSel,
  input  wire logic [2:0]           watchdogTimeoutConfig,
  input  wire logic [11:0]          adcRaw,
  input  wire logic                 faultClear,
  output logic                      logicRegEnable,
  output logic                      gateRegEnable,
  output logic                      refRegEnable,
  output logic [2:0]                gateVoltageOut,
  output logic [2:0]                gateUvThresholdOut,
  output logic                      conversionRequestCmd,
  output logic                      lvNormal,
  output logic                      spiEnable,
  output logic                      linkEnable,
  output logic                      hvDataEnable,
  output logic                      hvStatusReturnLink,
  output logic                      gateOn,
  output logic [11:0]               adcOut,
  output gds_pkg::gds_fault_t       faults,
  output logic                      otherFaultLatched,
  output logic                      irq_out_a_n,
  output logic                      irq_out_b_n
);

  // ----------------------------------------------------------------
  // Synchronised comparators
  // ----------------------------------------------------------------
  localparam int NCMP = $bits(gds_cmp_t);
  localparam int NPOR = $bits(gds_por_t);
  gds_cmp_t cmp;
  gds_por_t por;
  logic [NPOR-1:0] wdExp;

  generate
    for (genvar i = 0; i < NCMP; i++)
    begin : g_cmp
      gds_sync u_sync
      (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (cmpIn[i]),
        .dout    (cmp[i])
      );
    end
    for (genvar j = 0; j < NPOR; j++)
    begin : g_por
      gds_sync u_sync
      (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (porIn[j]),
        .dout    (por[j])
      );
      gds_wdog u_wdog
      (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .porLow     (por[j]),
        .timeoutSel (watchdogTimeoutConfig),
        .expired    (wdExp[j])
      );
    end
  endgenerate

  // Any supply under POR returns state to defaults, except that an expired watchdog latches its fault
  logic porAny;
  assign porAny = |por;

  // ----------------------------------------------------------------
  // Low-side sequencing
  // ----------------------------------------------------------------
  gds_lv_state_t lvQ;
  logic [15:0]   reqCntQ;
  logic          wasNormalQ;

  // Logic regulator follows input UV and input POR; no fault raised
  assign logicRegEnable = !cmp.lvInputSupplyUv && !por.lvInput;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lvQ <= LvOff;
    else if (porAny)
      lvQ <= LvOff;
    else
    begin
      case (lvQ)
        LvOff:     if (!cmp.lvLogicUv) lvQ <= LvRequest;
        LvRequest: if (cmp.lvLogicUv) lvQ <= LvOff;
                   else if (hvReplyValid) lvQ <= LvNormal;
        LvNormal:  if (cmp.lvLogicUv) lvQ <= LvDown;
        LvDown:    if (!cmp.lvLogicUv) lvQ <= LvRequest;
        default:   lvQ <= LvOff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reqCntQ              <= '0;
      conversionRequestCmd <= 1'b0;
    end
    else if (lvQ == LvRequest)
    begin
      conversionRequestCmd <= (reqCntQ == 16'(REQ_PERIOD_CYC - 1));
      reqCntQ <= (reqCntQ == 16'(REQ_PERIOD_CYC - 1)) ? '0 : reqCntQ + 16'h0001;
    end
    else
    begin
      reqCntQ              <= '0;
      conversionRequestCmd <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wasNormalQ <= 1'b0;
    else if (lvQ == LvNormal)
      wasNormalQ <= 1'b1;
    else if (lvQ == LvOff)
      wasNormalQ <= 1'b0;
  end

  assign lvNormal   = (lvQ == LvNormal);
  assign spiEnable  = !cmp.lvLogicUv && (lvQ != LvOff);
  assign linkEnable = !cmp.lvLogicUv && (lvQ != LvOff);

  // ----------------------------------------------------------------
  // High-side sequencing
  // ----------------------------------------------------------------
  gds_hv_state_t hvQ;
  logic          refWasGoodQ;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hvQ <= HvOff;
    else if (porAny)
      hvQ <= HvOff;
    else
    begin
      case (hvQ)
        HvOff:   if (!cmp.hvInputUv && cmp.hvLogicOk) hvQ <= HvRamp;
        HvRamp:  if (!cmp.gateSupplyUv && !cmp.referenceUv) hvQ <= HvRun;
                 else if (!cmp.hvLogicOk) hvQ <= HvOff;
        HvRun:   if (cmp.hvInputUv) hvQ <= HvDown;
        HvDown:  if (!cmp.hvLogicOk) hvQ <= HvOff;
                 else if (!cmp.hvInputUv) hvQ <= HvRun;
        default: hvQ <= HvOff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      refWasGoodQ <= 1'b0;
    else if (hvQ == HvOff)
      refWasGoodQ <= 1'b0;
    else if (hvQ == HvRun)
      refWasGoodQ <= 1'b1;
  end

  assign gateRegEnable      = (hvQ != HvOff);
  assign refRegEnable       = (hvQ != HvOff);
  assign gateVoltageOut     = gateSupplyVoltageSel;
  assign gateUvThresholdOut = gateUvThresholdSel;
  // Data messages accepted while falling until high-side logic drops out of regulation or POR
  assign hvDataEnable       = (hvQ == HvRun) || (hvQ == HvDown);
  assign hvStatusReturnLink = hvDataEnable && (|faults);

  // ----------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------
  logic poweredUp;
  logic refUvRun;
  assign poweredUp = refWasGoodQ && (lvQ != LvOff);
  assign refUvRun  = cmp.referenceUv && refWasGoodQ;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      faults            <= '0;
      otherFaultLatched <= 1'b0;
    end
    else if (porAny)
    begin
      faults            <= '0;
      otherFaultLatched <= 1'b0;
      if (|wdExp)
        faults.watchdog <= 1'b1;
    end
    else
    begin
      // Set wins over clear
      if (faultClear)
      begin
        faults            <= '0;
        otherFaultLatched <= 1'b0;
      end
      if (poweredUp)
      begin
        if (cmp.hvInputOv && !cmp.referenceUv)
          faults.hvSupplyOv <= 1'b1;
        if (cmp.gateSupplyUv && gateSelectA)
          faults.gateSupplyUv <= 1'b1;
        if (cmp.hvInputUv)
          faults.gateSupplyUv <= 1'b1;
        if (refUvRun)
          faults.referenceUv <= 1'b1;
        if (negSupplyMonitorEnable && cmp.negSupplyOor)
          faults.negSupplyOor <= 1'b1;
        if (linkFault || spiFault ||
            (!cmp.referenceUv && (overcurrentFault || desaturationFault)))
          otherFaultLatched <= 1'b1;
      end
      if (faults.watchdog && !faultClear)
        faults.watchdog <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Gate control
  // ----------------------------------------------------------------
  logic fsForce;
  logic gateSupplyDown;
  logic latchedAny;
  logic gateD;
  assign fsForce        = hvFailsafeEnable && hvFailsafeInput;
  assign gateSupplyDown = cmp.gateSupplyUv;
  assign latchedAny     = faults.hvSupplyOv || faults.negSupplyOor ||
                          faults.watchdog || otherFaultLatched ||
                          (faults.gateSupplyUv && gateSelectA);

  always_comb
  begin
    gateD = 1'b0;
    if (fsForce)
      gateD = 1'b1;
    else if (!poweredUp || !lvNormal)
      gateD = 1'b0;
    else if (cmp.hvInputOv || gateSupplyDown || cmp.referenceUv || latchedAny)
      gateD = 1'b0;
    else if (failsafeMode)
      gateD = failsafeGateStateInput;
    else
      gateD = pwmIn;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      gateOn <= 1'b0;
    else
      gateOn <= gateD;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      adcOut <= ADC_ZERO;
    else if (cmp.referenceUv || !hvDataEnable)
      adcOut <= ADC_ZERO;
    else
      adcOut <= adcRaw;
  end

  // ----------------------------------------------------------------
  // Interrupt pins, active low, masks gate reporting only
  // ----------------------------------------------------------------
  logic irqD;
  assign irqD = (faults.hvSupplyOv && !faultMaskTwo.hvSupplyOv) ||
                (faults.gateSupplyUv && !faultMaskTwo.gateSupplyUv) ||
                (faults.referenceUv && !faultMaskTwo.referenceUv) ||
                faults.negSupplyOor || faults.watchdog || otherFaultLatched ||
                fsForce;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_out_a_n <= 1'b1;
      irq_out_b_n <= 1'b1;
    end
    else if (wasNormalQ && cmp.lvLogicUv)
    begin
      irq_out_a_n <= 1'b0;
      irq_out_b_n <= 1'b0;
    end
    else
    begin
      irq_out_a_n <= !irqD;
      irq_out_b_n <= !irqD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gate_off_early_a: assert property (@(posedge sys_clk) disable iff (rst)
    !poweredUp && !fsForce |=> !gateOn) else $error("gate on before power-up");
  ov_gate_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmp.hvInputOv && !fsForce |=> !gateOn) else $error("gate on during overvoltage");
  no_early_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
    !poweredUp && !porAny && !$past(poweredUp) |=> !otherFaultLatched || $past(otherFaultLatched))
    else $error("fault latched before power-up");
  adc_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmp.referenceUv |=> adcOut == ADC_ZERO) else $error("adc not zero under ref uv");
  logic_reg_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmp.lvInputSupplyUv |-> !logicRegEnable) else $error("regulator on under uv");
  spi_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmp.lvLogicUv |-> !spiEnable && !linkEnable) else $error("spi active under uv");
  req_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    conversionRequestCmd && lvQ == LvRequest |=> !conversionRequestCmd)
    else $error("request not periodic");
  hv_reg_a: assert property (@(posedge sys_clk) disable iff (rst)
    hvQ == HvOff && cmp.hvInputUv |=> !gateRegEnable) else $error("hv regulator early");
  fs_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    fsForce |=> gateOn) else $error("failsafe not driving gate");
  wd_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
    porAny && (|wdExp) |=> faults.watchdog) else $error("watchdog not latched");
  irq_down_a: assert property (@(posedge sys_clk) disable iff (rst)
    wasNormalQ && cmp.lvLogicUv |=> !irq_out_a_n && !irq_out_b_n)
    else $error("interrupts not asserted at power-down");
endmodule

/* File: test/gds_hv_partner.sv */
// Behavioural high-side domain answering conversion requests
`timescale 1ns/1ps
module gds_hv_partner
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic conversionRequestCmd,
  input  wire logic replyOn,
  input  wire logic slowReply,
  output logic      hvReplyValid
);
  int waitCnt;

  // ----------------------------------------------------------------
  // Reply one cycle wide, promptly or after a long delay
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      waitCnt <= 0;
      hvReplyValid <= 1'b0;
    end
    else
    begin
      hvReplyValid <= (waitCnt == 1);
      if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
      else if (conversionRequestCmd && replyOn)
        waitCnt <= slowReply ? 40 : 1;
    end
  end
endmodule

/* File: test/tb.sv */
// Self-checking testbench for the supply sequencer
`timescale 1ns/1ps
module tb;
  import gds_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  gds_cmp_t cmp = 8'hE6;
  gds_por_t por = 4'h0;
  gds_mask_t msk = 3'h0;
  gds_fault_t flt;
  logic hvReply, pwm = 0, fsEn = 0, fsIn = 0, oc = 0, negEn = 0, fClr = 0;
  logic replyOn = 0, slowReply = 0, lvOk, gOn, req, lrEn, grEn, rrEn, spiEn, lnkEn;
  logic hvDat, hvStat, irqA, irqB, othF;
  logic gSelA = 0, fsMode = 0, failsafe_gate_state_input = 0;
  logic [2:0] vSel = 3'h5, uvSel = 3'h2, vOut, uvOut;
  logic [11:0] adcOut;
  int miscompares = 0;
  int testsRun = 0;
  int n;

  always #12.5 sys_clk = ~sys_clk;

  gds_sequencer dut_u (.sys_clk(sys_clk), .rst(rst), .cmpIn(cmp), .porIn(por),
    .hvReplyValid(hvReply), .pwmIn(pwm), .hvFailsafeEnable(fsEn), .hvFailsafeInput(fsIn),
    .failsafeGateStateInput(failsafe_gate_state_input), .failsafeMode(fsMode), .linkFault(1'b0), .spiFault(1'b0),
    .overcurrentFault(oc), .desaturationFault(oc), .overtempWarning(oc),
    .faultMaskTwo(msk), .negSupplyMonitorEnable(negEn), .gateSelectA(gSelA),
    .gateUvThresholdSel(uvSel), .gateSupplyVoltageSel(vSel),
    .watchdogTimeoutConfig(3'h0), .adcRaw(12'hABC), .faultClear(fClr),
    .logicRegEnable(lrEn), .gateRegEnable(grEn), .refRegEnable(rrEn),
    .gateVoltageOut(vOut), .gateUvThresholdOut(uvOut), .conversionRequestCmd(req),
    .lvNormal(lvOk), .spiEnable(spiEn), .linkEnable(lnkEn), .hvDataEnable(hvDat),
    .hvStatusReturnLink(hvStat), .gateOn(gOn), .adcOut(adcOut), .faults(flt),
    .otherFaultLatched(othF), .irq_out_a_n(irqA), .irq_out_b_n(irqB));

  gds_hv_partner hv_u (.sys_clk(sys_clk), .rst(rst), .conversionRequestCmd(req),
    .replyOn(replyOn), .slowReply(slowReply), .hvReplyValid(hvReply));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic clr();
    // Let comparator changes clear the synchroniser first
    step(3);
    fClr = 1'b1;
    step(1);
    fClr = 1'b0;
    step(4);
  endtask

  task automatic close_out();
    if (miscompares == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    step(4);
    rst = 1'b0;
    step(5);
    chk({irqA, irqB, gOn, lrEn, spiEn, lnkEn, grEn}, 12'h060);
    chk({vOut, uvOut}, 12'h02A);
    vSel = 3'h2;
    uvSel = 3'h7;
    step(1);
    chk({vOut, uvOut}, 12'h017);
    cmp.lvInputSupplyUv = 1'b0;
    step(5);
    chk(lrEn, 1'b1);
    chk(flt, 5'h00);
    cmp.lvLogicUv = 1'b0;
    n = 0;
    for (int k = 0; k < 1000 && n < 2; k++)
    begin
      step(1);
      if (req === 1'b1)
        n++;
    end
    chk(n, 2);
    chk(lvOk, 1'b0);
    chk({spiEn, lnkEn}, 2'h3);
    replyOn = 1'b1;
    slowReply = 1'b1;
    for (int k = 0; k < 600 && lvOk !== 1'b1; k++)
      step(1);
    chk(lvOk, 1'b1);
    chk({grEn, rrEn}, 2'h0);
    cmp.hvInputUv = 1'b0;
    cmp.hvLogicOk = 1'b1;
    step(5);
    chk({grEn, rrEn}, 2'h3);
    cmp.gateSupplyUv = 1'b0;
    oc = 1'b1;
    pwm = 1'b1;
    cmp.hvInputOv = 1'b1;
    step(10);
    chk({gOn, hvDat, adcOut}, 12'h000);
    chk(flt, 5'h00);
    chk(othF, 1'b0);
    oc = 1'b0;
    cmp.hvInputOv = 1'b0;
    step(5);
    cmp.referenceUv = 1'b0;
    step(5);
    chk({gOn, hvDat, hvStat}, 3'h6);
    chk(flt, 5'h00);
    chk(adcOut, 12'hABC);
    pwm = 1'b0;
    step(2);
    chk(gOn, 1'b0);
    pwm = 1'b1;
    cmp.negSupplyOor = 1'b1;
    step(5);
    chk({gOn, flt.negSupplyOor}, 2'h2);
    negEn = 1'b1;
    step(5);
    chk({gOn, flt.negSupplyOor}, 2'h1);
    cmp.negSupplyOor = 1'b0;
    clr();
    chk(gOn, 1'b1);
    cmp.hvInputOv = 1'b1;
    step(5);
    chk({gOn, flt.hvSupplyOv, lnkEn}, 3'h3);
    chk({irqA, irqB}, 2'h0);
    cmp.hvInputOv = 1'b0;
    step(3);
    chk(flt.hvSupplyOv, 1'b1);
    clr();
    chk({gOn, irqA, irqB}, 3'h7);
    msk = 3'h7;
    cmp.hvInputOv = 1'b1;
    step(5);
    chk({flt.hvSupplyOv, irqA, irqB}, 3'h7);
    cmp.hvInputOv = 1'b0;
    clr();
    msk = 3'h0;
    fsEn = 1'b1;
    fsIn = 1'b1;
    cmp.gateSupplyUv = 1'b1;
    step(5);
    chk(gOn, 1'b1);
    fsIn = 1'b0;
    step(5);
    chk({gOn, lnkEn}, 2'h1);
    gSelA = 1'b1;
    step(2);
    chk(flt.gateSupplyUv, 1'b1);
    fsEn = 1'b0;
    cmp.gateSupplyUv = 1'b0;
    step(5);
    chk(gOn, 1'b0);
    gSelA = 1'b0;
    clr();
    cmp.referenceUv = 1'b1;
    step(5);
    chk({gOn, lnkEn, hvStat, adcOut}, 15'h3000);
    cmp.referenceUv = 1'b0;
    clr();
    chk(gOn, 1'b1);
    fsMode = 1'b1;
    step(2);
    chk(gOn, 1'b0);
    failsafe_gate_state_input = 1'b1;
    step(2);
    chk(gOn, 1'b1);
    fsMode = 1'b0;
    msk = 3'h7;
    cmp.hvInputUv = 1'b1;
    step(5);
    chk({flt.gateSupplyUv, gOn}, 2'h3);
    cmp.lvInputSupplyUv = 1'b1;
    step(5);
    chk(lrEn, 1'b0);
    cmp.lvLogicUv = 1'b1;
    step(5);
    chk({spiEn, lnkEn, irqA, irqB}, 4'h0);
    por.lvInput = 1'b1;
    step(1000);
    por.lvInput = 1'b0;
    step(10);
    chk({flt, gOn, lvOk}, 7'h00);
    por.lvInput = 1'b1;
    step(4400);
    por.lvInput = 1'b0;
    step(10);
    chk(flt.watchdog, 1'b1);
    close_out();
  end
endmodule
